// [clc_cell.sv]
// Configurable logic cell: tables, carry, memory mode, crossbar, registers
module clc_cell (
    // Clock and reset
    input  wire logic            clk_sys_in,
    input  wire logic            rstn_in,
    // Configuration, static, same clock
    input  wire clc_pkg::clc_cfg_t cfg_in,
    // Pins from the fabric
    input  wire clc_pkg::clc_pins_t pins_in,
    // Cell outputs
    output logic                 registered_output_x_out,
    output logic                 registered_output_y_out,
    output logic                 comb_output_x_out,
    output logic                 comb_output_y_out,
    output logic [3:0]           output_enable_out,
    output logic                 carry_out
);
    import clc_pkg::*;

    //======================================================================
    // Input synchronisers
    //======================================================================
    clc_pins_t sync1_q, sync1_d;                          // First stage
    clc_pins_t sync2_q, sync2_d;                          // Second stage
    logic      clk_prev_q, clk_prev_d;                    // Cell clock history

    // Shift pins through two stages
    always_comb begin
        sync1_d    = pins_in;
        sync2_d    = sync1_q;
        clk_prev_d = sync2_q.cell_clk;
    end

    // Register the synchroniser chain
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            clk_prev_q <= CLC_BIT_RESET;
        end else begin
            sync1_q    <= sync1_d;
            sync2_q    <= sync2_d;
            clk_prev_q <= clk_prev_d;
        end
    end

    //======================================================================
    // Control crossbar
    //======================================================================
    logic [CLC_CTRL_NUM-1:0] int_ctl;                     // Internal controls

    for (genvar i = 0; i < CLC_CTRL_NUM; i++) begin : g_xbar
        assign int_ctl[i] = sync2_q.ctrl[cfg_in.ctrl_sel[i]];
    end

    logic ninth_function_input;                           // H table third input
    logic direct_data;                                    // Direct data input
    logic set_reset;                                      // Set/reset line
    logic register_clock_enable;                          // Shared enable

    assign ninth_function_input  = int_ctl[CLC_IDX_NINTH];
    assign direct_data           = int_ctl[CLC_IDX_DIN];
    assign set_reset             = int_ctl[CLC_IDX_SR];
    assign register_clock_enable = int_ctl[CLC_IDX_CE];

    //======================================================================
    // Memory mode
    //======================================================================
    logic ram_mode;                                       // Tables are memory
    logic we_f, we_g;                                     // Bank writes
    logic wd_f, wd_g;                                     // Bank write data
    logic rd_f, rd_g;                                     // Bank read data
    logic fifth_address_line;                             // 32x1 bank select
    logic single_write_data_line;                         // 32x1 data

    assign ram_mode               = (cfg_in.mem_mode != CLC_LOGIC);
    assign fifth_address_line     = ninth_function_input;
    assign single_write_data_line = direct_data;

    // Steer control lines onto the memory write port
    always_comb begin
        we_f = 1'b0;
        we_g = 1'b0;
        wd_f = 1'b0;
        wd_g = 1'b0;
        if (cfg_in.mem_mode == CLC_RAM16X2) begin
            we_f = set_reset;
            we_g = set_reset;
            wd_f = ninth_function_input;
            wd_g = direct_data;
        end else if (cfg_in.mem_mode == CLC_RAM32X1) begin
            we_f = set_reset && !fifth_address_line;
            we_g = set_reset && fifth_address_line;
            wd_f = single_write_data_line;
            wd_g = single_write_data_line;
        end
    end

    clc_lut_ram #(
        .DEPTH      (CLC_LUT_DEPTH)
    ) u_ram (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .addr_f_in  (sync2_q.f),
        .addr_g_in  (sync2_q.g),
        .we_f_in    (we_f),
        .we_g_in    (we_g),
        .wd_f_in    (wd_f),
        .wd_g_in    (wd_g),
        .rd_f_out   (rd_f),
        .rd_g_out   (rd_g)
    );

    // In 32x1 mode the fifth address picks which bank appears on F
    logic rd_f_sel;                                       // F memory output
    assign rd_f_sel = (cfg_in.mem_mode == CLC_RAM32X1 && fifth_address_line)
                    ? rd_g : rd_f;

    //======================================================================
    // Function generators and carry
    //======================================================================
    logic f_lut, g_lut;                                   // Table look-ups
    logic f_b1, g_b1;                                     // Operand, maybe inverted
    logic f_sum, g_sum;                                   // Sum bits
    logic carry_mid, carry_end;                           // Carry chain
    logic f_val, g_val, h_val;                            // Function outputs

    // Any input combination addresses a full table entry
    assign f_lut = cfg_in.f_table[sync2_q.f];
    assign g_lut = cfg_in.g_table[sync2_q.g];

    // Two-bit ripple: F then G, operand 1 inverted for borrow
    always_comb begin
        f_b1      = sync2_q.f[1] ^ cfg_in.borrow;
        g_b1      = sync2_q.g[1] ^ cfg_in.borrow;
        f_sum     = sync2_q.f[0] ^ f_b1 ^ sync2_q.carry_in;
        carry_mid = (sync2_q.f[0] & f_b1) | (sync2_q.carry_in & (sync2_q.f[0] ^ f_b1));
        g_sum     = sync2_q.g[0] ^ g_b1 ^ carry_mid;
        carry_end = (sync2_q.g[0] & g_b1) | (carry_mid & (sync2_q.g[0] ^ g_b1));
    end

    // Pick memory, carry or plain table per function
    always_comb begin
        if (ram_mode) begin
            f_val = rd_f_sel;
            g_val = rd_g;
        end else if (cfg_in.carry_en) begin
            f_val = f_sum;
            g_val = g_sum;
        end else begin
            f_val = f_lut;
            g_val = g_lut;
        end
        h_val = cfg_in.h_table[{ninth_function_input, g_val, f_val}];
    end

    //======================================================================
    // Cell registers
    //======================================================================
    logic                   init_pend_q, init_pend_d;     // Power-up load
    logic [CLC_REG_NUM-1:0] cell_q, cell_d;               // X is bit 0
    logic [CLC_REG_NUM-1:0] cell_edge;                    // Active cell edge
    logic [CLC_REG_NUM-1:0] cell_data;                    // Selected data
    logic                   gsr_force;                    // Global init force
    logic                   sr_active;                    // Set/reset in logic mode

    assign init_pend_d = 1'b0;
    assign gsr_force   = sync2_q.gsr || init_pend_q;
    assign sr_active   = set_reset && !ram_mode;

    for (genvar j = 0; j < CLC_REG_NUM; j++) begin : g_reg
        // Detect the configured edge of the cell clock
        assign cell_edge[j] = cfg_in.regs[j].rise_edge
                            ? ( sync2_q.cell_clk && !clk_prev_q)
                            : (!sync2_q.cell_clk &&  clk_prev_q);

        // Next value: global init, then set/reset, then enabled edge
        always_comb begin
            case (cfg_in.regs[j].src)
                CLC_SRC_F: cell_data[j] = f_val;
                CLC_SRC_G: cell_data[j] = g_val;
                CLC_SRC_H: cell_data[j] = h_val;
                default:   cell_data[j] = direct_data;
            endcase
            cell_d[j] = cell_q[j];
            if (gsr_force) begin
                cell_d[j] = cfg_in.regs[j].init_set;
            end else if (sr_active) begin
                cell_d[j] = cfg_in.regs[j].sr_set;
            end else if (cell_edge[j]
                         && (register_clock_enable || !cfg_in.regs[j].ce_used)) begin
                cell_d[j] = cell_data[j];
            end
        end
    end

    // Register the cell flops
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_pend_q <= CLC_PEND_RESET;
            cell_q      <= '0;
        end else begin
            init_pend_q <= init_pend_d;
            cell_q      <= cell_d;
        end
    end

    //======================================================================
    // Output stage
    //======================================================================
    logic                   comb_x_q, comb_x_d;           // F output copy
    logic                   comb_y_q, comb_y_d;           // G output copy
    logic [CLC_OUT_NUM-1:0] oe_q, oe_d;                   // Output enables
    logic                   carry_q, carry_d;             // Carry out

    // Tri-state only touches the enables, never the cell flops
    always_comb begin
        comb_x_d = f_val;
        comb_y_d = g_val;
        oe_d     = {CLC_OUT_NUM{!sync2_q.gts}};
        carry_d  = carry_end;
    end

    // Register outputs
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            comb_x_q <= CLC_BIT_RESET;
            comb_y_q <= CLC_BIT_RESET;
            oe_q     <= '0;
            carry_q  <= CLC_BIT_RESET;
        end else begin
            comb_x_q <= comb_x_d;
            comb_y_q <= comb_y_d;
            oe_q     <= oe_d;
            carry_q  <= carry_d;
        end
    end

    assign registered_output_x_out = cell_q[0];
    assign registered_output_y_out = cell_q[1];
    assign comb_output_x_out       = comb_x_q;
    assign comb_output_y_out       = comb_y_q;
    assign output_enable_out       = oe_q;
    assign carry_out               = carry_q;

    //======================================================================
    // Checks
    //======================================================================
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    sequence quiet_edge_s;
        !gsr_force && !sr_active && cell_edge[0];
    endsequence

    gsr_init_a: assert property (gsr_force |=> cell_q == {cfg_in.regs[1].init_set,
        cfg_in.regs[0].init_set})
        else $error("global init did not load configured values");

    sr_async_a: assert property (!gsr_force && sr_active && !cell_edge[0]
        |=> registered_output_x_out == cfg_in.regs[0].sr_set)
        else $error("set/reset ignored without clock edge");

    ce_hold_a: assert property (!gsr_force && !sr_active && cell_edge[1]
        && cfg_in.regs[1].ce_used && !register_clock_enable |=> $stable(cell_q[1]))
        else $error("register changed with enable low");

    edge_load_a: assert property ((quiet_edge_s and !cfg_in.regs[0].ce_used)
        |=> cell_q[0] == $past(cell_data[0]))
        else $error("register missed its active edge");

    no_edge_a: assert property (!gsr_force && !sr_active && !cell_edge[1]
        |=> $stable(cell_q[1]))
        else $error("register loaded without an active edge");

    tristate_oe_a: assert property (sync2_q.gts |=> output_enable_out == '0)
        else $error("outputs driven during tri-state");

    tristate_keep_a: assert property (sync2_q.gts && !gsr_force && !sr_active
        && cell_edge == '0 |=> $stable(cell_q))
        else $error("tri-state altered register state");

    crossbar_map_a: assert property (set_reset == sync2_q.ctrl[cfg_in.ctrl_sel[CLC_IDX_SR]])
        else $error("set/reset not mapped from selected control");

    carry_chain_a: assert property (!ram_mode && cfg_in.carry_en
        |=> carry_out == $past(carry_end) && comb_output_x_out == $past(f_sum))
        else $error("carry or sum output wrong");

endmodule : clc_cell

// [clc_fabric.sv]
// Fabric model that bursts the cell clock pin
module clc_fabric (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // Burst request
    input  wire logic run_in,
    // Cell clock pin
    output logic      cell_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q;                                    // Half period count
    // Toggles every four system cycles, stands low outside bursts
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q        <= 2'h0;
            cell_clk_out <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (!run_in) begin
                cell_clk_out <= 1'b0;
            end else if (cnt_q == 2'h3) begin
                cell_clk_out <= ~cell_clk_out;
            end
        end
    end
endmodule : clc_fabric

// [clc_lut_ram.sv]
// Two-bank look-up table memory with registered read data
module clc_lut_ram #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     clk_sys_in,
    input  wire logic                     rstn_in,
    // Addresses
    input  wire logic [$clog2(DEPTH)-1:0] addr_f_in,
    input  wire logic [$clog2(DEPTH)-1:0] addr_g_in,
    // Write side
    input  wire logic                     we_f_in,
    input  wire logic                     we_g_in,
    input  wire logic                     wd_f_in,
    input  wire logic                     wd_g_in,
    // Read side
    output logic                          rd_f_out,
    output logic                          rd_g_out
);
    import clc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Refuse a depth that the table addressing cannot serve
    if (DEPTH != CLC_LUT_DEPTH) begin : g_depth_check
        $error("clc_lut_ram: depth must match table");
    end

    logic [1:0][DEPTH-1:0] mem_q, mem_d;                  // Bank 0 F, bank 1 G
    logic [1:0]            rd_q,  rd_d;                   // Registered reads
    logic [1:0][AW-1:0]    addr;                          // Per-bank address
    logic [1:0]            we, wd;                        // Per-bank write

    assign addr = {addr_g_in, addr_f_in};
    assign we   = {we_g_in, we_f_in};
    assign wd   = {wd_g_in, wd_f_in};

    //======================================================================
    // Storage banks
    //======================================================================
    for (genvar b = 0; b < 2; b++) begin : g_bank
        // Write one cell, read the addressed cell as it stood
        always_comb begin
            mem_d[b] = mem_q[b];
            if (we[b]) begin
                mem_d[b][addr[b]] = wd[b];
            end
            rd_d[b] = mem_q[b][addr[b]];
        end
    end

    // Register banks and read data
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_q <= '0;
            rd_q  <= '0;
        end else begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
        end
    end

    assign rd_f_out = rd_q[0];
    assign rd_g_out = rd_q[1];

    //======================================================================
    // Checks
    //======================================================================
    // A written cell reads back once the address holds without a write
    sequence wr_then_hold_s;
        we_f_in ##1 (!we_f_in && $stable(addr_f_in));
    endsequence

    ram_readback_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        wr_then_hold_s |=> (rd_f_out == $past(wd_f_in, 2)))
        else $error("memory read data differs from last write");

endmodule : clc_lut_ram

// [clc_pkg.sv]
// Shared constants, configuration types and pin bundles of the logic cell
//==========================================================================
// Overview of operation
// - Two 4-input tables plus third combining function
// - Every table input fully usable and swappable
// - Tables optionally act as read/write memory
// - Memory forms 16x2 or 32x1 array
// - 16x2: ninth, direct data, set/reset become write
// - 32x1: fifth address line and write data line
// - Register set or reset acts without cell clock
// - Four outputs: two registered, two combinational
// - Shared clock enable, may be disabled per register
// - Global set/reset forces configured initial values
// - Global reset net from pin through two-stage synchroniser
// - Per-register rising or falling edge select
// - Register data from F, G, H or direct
// - Dedicated carry and borrow logic in F, G
// - Control inputs map to internal signals arbitrarily
// - Global tri-state floats outputs, keeps state
//==========================================================================
package clc_pkg;

    //======================================================================
    // Sizes
    //======================================================================
    localparam int CLC_LUT_INPUTS = 4;                    // Inputs per table
    localparam int CLC_LUT_DEPTH  = 16;                   // Entries per table
    localparam int CLC_H_DEPTH    = 8;                    // Entries of third table
    localparam int CLC_CTRL_NUM   = 4;                    // Control inputs
    localparam int CLC_REG_NUM    = 2;                    // Cell registers
    localparam int CLC_OUT_NUM    = 4;                    // Cell outputs

    //======================================================================
    // Internal control signal positions in the crossbar
    //======================================================================
    localparam int CLC_IDX_NINTH  = 0;                    // Ninth function input
    localparam int CLC_IDX_DIN    = 1;                    // Direct data input
    localparam int CLC_IDX_SR     = 2;                    // Set/reset line
    localparam int CLC_IDX_CE     = 3;                    // Register clock enable

    //======================================================================
    // Register data source codes
    //======================================================================
    localparam logic [1:0] CLC_SRC_F   = 2'h0;            // First function
    localparam logic [1:0] CLC_SRC_G   = 2'h1;            // Second function
    localparam logic [1:0] CLC_SRC_H   = 2'h2;            // Third function
    localparam logic [1:0] CLC_SRC_DIN = 2'h3;            // Direct data

    //======================================================================
    // Values after reset
    //======================================================================
    localparam logic CLC_BIT_RESET  = 1'h0;               // Plain flops
    localparam logic CLC_PEND_RESET = 1'h1;               // Initial load pending

    //======================================================================
    // Types
    //======================================================================
    typedef enum logic [1:0] {
        CLC_LOGIC,                                        // Tables hold logic
        CLC_RAM16X2,                                      // Two 16x1 memories
        CLC_RAM32X1                                       // One 32x1 memory
    } clc_mem_mode_t;

    typedef struct packed {
        logic       rise_edge;                            // 1 rising, 0 falling
        logic       ce_used;                              // 0 always loads
        logic       init_set;                             // Global init value
        logic       sr_set;                               // Set/reset value
        logic [1:0] src;                                  // Data source code
    } clc_reg_cfg_t;

    typedef struct packed {
        logic [CLC_LUT_DEPTH-1:0]  f_table;               // First truth table
        logic [CLC_LUT_DEPTH-1:0]  g_table;               // Second truth table
        logic [CLC_H_DEPTH-1:0]    h_table;               // Index {ninth,G,F}
        clc_mem_mode_t             mem_mode;              // Logic or memory
        logic                      carry_en;              // Arithmetic mode
        logic                      borrow;                // Subtract operand
        logic [CLC_CTRL_NUM-1:0][1:0] ctrl_sel;           // Crossbar selects
        clc_reg_cfg_t [CLC_REG_NUM-1:0] regs;             // Index 0 is X
    } clc_cfg_t;

    typedef struct packed {
        logic [CLC_LUT_INPUTS-1:0] f;                     // First table inputs
        logic [CLC_LUT_INPUTS-1:0] g;                     // Second table inputs
        logic [CLC_CTRL_NUM-1:0]   ctrl;                  // External controls
        logic                      cell_clk;              // Cell clock pin
        logic                      carry_in;              // Carry chain in
        logic                      gsr;                   // Global set/reset
        logic                      gts;                   // Global tri-state
    } clc_pins_t;

endpackage : clc_pkg

// [test_configurable_logic_cell.sv]
// Self-checking bench of the configurable logic cell
module test_configurable_logic_cell;
    timeunit 1ns;
    timeprecision 1ns;
    import clc_pkg::*;
    //==================================================================
    // Signals
    //==================================================================
    logic      clk_sys_in;                                // System clock
    logic      rstn_in;                                   // Reset, active low
    clc_cfg_t  cfg_q;                                     // Configuration
    clc_pins_t pins_q;                                    // Pins but cell clock
    clc_pins_t pins_w;                                    // Pins seen by cell
    logic      run_q;                                     // Burst request
    logic      kclk_w;                                    // Cell clock
    logic      rx_w, ry_w, cx_w, cy_w, co_w;              // Cell outputs
    logic [3:0] oe_w;                                     // Output enables
    clc_cfg_t  c;                                         // Next configuration
    clc_pins_t p;                                         // Next pins
    int        errors;                                    // Mismatches
    int        num_checks;                                // Comparisons
    // Merge fabric clock into the pin bundle
    always_comb begin
        pins_w          = pins_q;
        pins_w.cell_clk = kclk_w;
    end
    // Clock
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    clc_fabric FAB (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .run_in(run_q),
        .cell_clk_out(kclk_w));
    clc_cell DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cfg_in(cfg_q),
        .pins_in(pins_w), .registered_output_x_out(rx_w), .registered_output_y_out(ry_w),
        .comb_output_x_out(cx_w), .comb_output_y_out(cy_w), .output_enable_out(oe_w),
        .carry_out(co_w));
    //==================================================================
    // Tasks
    //==================================================================
    // Compare and count
    task automatic chk(input logic [3:0] e, input logic [3:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // Apply config, pins and burst, then let outputs settle
    task automatic drive(input logic r);
        @(posedge clk_sys_in);
        cfg_q  <= c;
        pins_q <= p;
        run_q  <= r;
        repeat (24) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask : drive
    // Report and end
    task automatic complete_run;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    //==================================================================
    // Sequence
    //==================================================================
    initial begin
        errors = 0;
        num_checks = 0;
        c = '0;
        c.f_table = 16'h8000;                             // F is AND
        c.g_table = 16'h0001;                             // G is NOR
        c.h_table = 8'h80;                                // H is AND
        c.ctrl_sel = {2'h2, 2'h3, 2'h1, 2'h0};            // CE pin2, SR pin3
        c.regs = {6'h16, 6'h28};                          // Y fall/CE/H, X rise/F
        p = '0;
        cfg_q = c;
        pins_q = p;
        run_q = 1'b0;
        rstn_in = 1'b0;
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        drive(1'b0);
        chk(4'h9, {rx_w, ry_w, cx_w, cy_w});
        p.f = 4'hF;
        drive(1'b0);
        chk(4'hB, {rx_w, ry_w, cx_w, cy_w});
        for (int i = 0; i < 4; i++) begin
            p.f = 4'hF ^ (4'h1 << i);
            p.g = 4'h1 << i;
            drive(1'b0);
            chk(4'h8, {rx_w, ry_w, cx_w, cy_w});
        end
        p.f = 4'h0;
        p.g = 4'h0;
        drive(1'b1);
        chk(4'h1, {rx_w, ry_w, cx_w, cy_w});
        p.f = 4'hF;
        p.ctrl = 4'h1;
        drive(1'b1);
        chk(4'hB, {rx_w, ry_w, cx_w, cy_w});
        p.ctrl = 4'h5;
        drive(1'b0);
        chk(4'hF, {rx_w, ry_w, cx_w, cy_w});
        p.gts = 1'b1;
        drive(1'b0);
        chk(4'h0, oe_w);
        chk(4'hF, {rx_w, ry_w, cx_w, cy_w});
        p.gts = 1'b0;
        p.ctrl = 4'h9;
        drive(1'b0);
        chk(4'hF, oe_w);
        chk(4'h7, {rx_w, ry_w, cx_w, cy_w});
        p.ctrl = 4'h1;
        p.gsr = 1'b1;
        drive(1'b0);
        p.gsr = 1'b0;
        drive(1'b0);
        chk(4'hB, {rx_w, ry_w, cx_w, cy_w});
        c.mem_mode = CLC_RAM16X2;
        p.f = 4'h5;
        p.g = 4'h5;
        for (int i = 0; i < 2; i++) begin
            p.ctrl = (i == 0) ? 4'h9 : 4'hA;
            drive(1'b0);
            p.ctrl = 4'h0;
            drive(1'b0);
            chk((i == 0) ? 4'hA : 4'h9, {rx_w, ry_w, cx_w, cy_w});
        end
        c.mem_mode = CLC_RAM32X1;
        p.ctrl = 4'h1;
        drive(1'b0);
        chk(4'hB, {rx_w, ry_w, cx_w, cy_w});
        p.ctrl = 4'hA;
        drive(1'b0);
        p.ctrl = 4'h0;
        drive(1'b0);
        chk(4'hB, {rx_w, ry_w, cx_w, cy_w});
        c.mem_mode = CLC_LOGIC;
        c.carry_en = 1'b1;
        p.f = 4'h3;
        p.g = 4'h0;
        drive(1'b0);
        chk(4'h9, {rx_w, ry_w, cx_w, cy_w});
        p.f = 4'h0;
        p.g = 4'h3;
        p.carry_in = 1'b1;
        drive(1'b0);
        chk(4'hA, {rx_w, ry_w, cx_w, cy_w});
        chk(4'h1, {3'h0, co_w});
        c.borrow = 1'b1;
        p.f = 4'h1;
        p.g = 4'h0;
        drive(1'b0);
        chk(4'hA, {rx_w, ry_w, cx_w, cy_w});
        chk(4'h1, {3'h0, co_w});
        complete_run();
    end
endmodule : test_configurable_logic_cell
